/* design/sdr_cfg.svh */
// Constants of the serial converter input register block
`ifndef SDR_CFG_SVH
`define SDR_CFG_SVH
`define SDR_WIDTH_HI 12
`define SDR_WIDTH_LO 10
`define SDR_DAC_RESET 12'h000
`define SDR_SHIFT_RESET 12'h000
`define SDR_BUF_DEPTH 2
`endif

/* design/sdr_pkg.sv */
// Types of the serial converter input register block
`include "sdr_cfg.svh"
package sdr_pkg;
   typedef struct packed {
      logic [`SDR_WIDTH_HI-1:0] code;
      logic narrow;
   } sdr_word_t;
   typedef struct packed {
      logic clear_n;
      logic load_strobe_n;
   } sdr_ctl_t;
   typedef enum logic [1:0] {SDR_IDLE, SDR_CLEAR, SDR_LOAD} sdr_state_t;
endpackage

/* design/sdr_input_ctrl.sv */
// Double-buffered serial input register of a voltage-output converter
//
// Behaviour
// - Serial data enters shift register directly
// - Low load strobe copies shift register
// - Transfer lasts while strobe low, then holds
// - Low clear zeroes DAC register only
// - Clear release, strobe high: stay zero
// - Clear release, strobe low: load old contents
// - Wide variant: twelve bits, MSB first
// - Narrow variant: ten bits, MSB first
// - DAC code is unsigned binary
`timescale 1ns/1ps
`include "sdr_cfg.svh"
module sdr_input_ctrl (
   // Core clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Link from the host
   input wire logic i_link_clk,
   input wire logic i_serial_data_in,
   input wire logic i_load_strobe_n,
   input wire logic i_clear_n,
   // Variant select: high selects the ten-bit variant
   input wire logic i_narrow,
   // DAC code towards the converter
   input wire logic i_code_ready,
   output logic o_code_valid,
   output logic [`SDR_WIDTH_HI-1:0] o_code,
   output logic o_code_narrow,
   output logic [`SDR_WIDTH_HI-1:0] o_dac_reg
);
   //------------------------------------------------------------
   // Link clock domain: shift register
   //------------------------------------------------------------
   logic [`SDR_WIDTH_HI-1:0] shift_q;
   logic [`SDR_WIDTH_HI-1:0] shift_d;
   logic shift_en;
   logic [`SDR_WIDTH_HI-1:0] shift_mask;
   logic [1:0] narrow_sync_q;
   // Width mask keeps only the resolution width of bits
   function automatic logic [`SDR_WIDTH_HI-1:0] width_mask(input logic narrow);
      logic [`SDR_WIDTH_HI-1:0] m;
      m = narrow ? `SDR_WIDTH_HI'(12'h03ff) : `SDR_WIDTH_HI'(12'h0fff);
      return m;
   endfunction
   assign shift_mask = width_mask(narrow_sync_q[1]);
   // Strobe and clear gate the link clock directly: that clock stands still
   // between frames, so a synchroniser in this domain would never settle in
   // time. The host keeps both steady around its own clock edges.
   // shift only while both controls high
   assign shift_en = i_load_strobe_n & i_clear_n;
   // data enters LSB directly; MSB first, oldest bits fall off
   assign shift_d = shift_en ? ({shift_q[`SDR_WIDTH_HI-2:0], i_serial_data_in} & shift_mask)
                             : shift_q;
   always_ff @(posedge i_link_clk or posedge i_reset) begin
      if (i_reset) begin
         narrow_sync_q <= 2'b00;
      end else begin
         narrow_sync_q <= {narrow_sync_q[0], i_narrow};
      end
   end
   always_ff @(posedge i_link_clk or posedge i_reset) begin
      if (i_reset) begin
         shift_q <= `SDR_SHIFT_RESET;
      end else begin
         shift_q <= shift_d;
      end
   end
   //------------------------------------------------------------
   // Core domain: synchronise controls and word
   //------------------------------------------------------------
   // Shift register is stable whenever the strobe or clear is low, since the
   // link clock cannot shift then; so the word is safe to sample as a bus.
   logic [1:0] ld_sync_q;
   logic [1:0] clr_sync_q;
   logic [`SDR_WIDTH_HI-1:0] word_s1_q;
   logic [`SDR_WIDTH_HI-1:0] word_s2_q;
   logic [1:0] nar_core_q;
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         ld_sync_q <= 2'b11;
         clr_sync_q <= 2'b00;
         word_s1_q <= `SDR_SHIFT_RESET;
         word_s2_q <= `SDR_SHIFT_RESET;
         nar_core_q <= 2'b00;
      end else begin
         ld_sync_q <= {ld_sync_q[0], i_load_strobe_n};
         clr_sync_q <= {clr_sync_q[0], i_clear_n};
         word_s1_q <= shift_q;
         word_s2_q <= word_s1_q;
         nar_core_q <= {nar_core_q[0], i_narrow};
      end
   end
   logic ld_n_s;
   logic clr_n_s;
   assign ld_n_s = ld_sync_q[1];
   assign clr_n_s = clr_sync_q[1];
   //------------------------------------------------------------
   // DAC register and control state
   //------------------------------------------------------------
   sdr_pkg::sdr_state_t state_q;
   sdr_pkg::sdr_state_t state_d;
   logic [`SDR_WIDTH_HI-1:0] dac_q;
   logic [`SDR_WIDTH_HI-1:0] dac_d;
   logic dac_change;
   assign state_d = !clr_n_s ? sdr_pkg::SDR_CLEAR
                  : (!ld_n_s ? sdr_pkg::SDR_LOAD : sdr_pkg::SDR_IDLE);
   always_comb begin
      unique case (state_d)
         sdr_pkg::SDR_CLEAR: dac_d = `SDR_DAC_RESET;
         // load follows; after clear release takes held contents
         sdr_pkg::SDR_LOAD: dac_d = word_s2_q;
         // latched value, zero if last cleared
         sdr_pkg::SDR_IDLE: dac_d = dac_q;
      endcase
   end
   assign dac_change = (dac_d != dac_q);
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= sdr_pkg::SDR_CLEAR;
         dac_q <= `SDR_DAC_RESET;
      end else begin
         state_q <= state_d;
         dac_q <= dac_d;
      end
   end
   //------------------------------------------------------------
   // Two-entry buffer of new DAC codes
   //------------------------------------------------------------
   // codes are plain unsigned binary with the variant flag alongside
   sdr_pkg::sdr_word_t buf_q [`SDR_BUF_DEPTH];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] count_q;
   logic buf_full;
   logic buf_push;
   logic buf_pop;
   sdr_pkg::sdr_word_t push_word;
   assign buf_full = (count_q == 2'd2);
   // A full buffer drops the oldest pending slot? No: the register still updates,
   // but a code that changes while the buffer is full is not pushed; queued codes are kept.
   assign buf_push = dac_change & !buf_full;
   assign buf_pop = o_code_valid & i_code_ready;
   assign push_word = '{code: dac_d, narrow: nar_core_q[1]};
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'd0;
      end else begin
         wr_ptr_q <= wr_ptr_q ^ buf_push;
         rd_ptr_q <= rd_ptr_q ^ buf_pop;
         count_q <= 2'(count_q + {1'b0, buf_push} - {1'b0, buf_pop});
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (buf_push) begin
         buf_q[wr_ptr_q] <= push_word;
      end
   end
   logic [1:0] count_d;
   logic rd_ptr_d;
   assign count_d = 2'(count_q + {1'b0, buf_push} - {1'b0, buf_pop});
   assign rd_ptr_d = rd_ptr_q ^ buf_pop;
   //------------------------------------------------------------
   // Registered outputs
   //------------------------------------------------------------
   sdr_pkg::sdr_word_t head_d;
   assign head_d = (buf_push && (count_q - {1'b0, buf_pop}) == 2'd0) ? push_word
                 : buf_q[rd_ptr_d];
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_code_valid <= 1'b0;
         o_code <= `SDR_DAC_RESET;
         o_code_narrow <= 1'b0;
         o_dac_reg <= `SDR_DAC_RESET;
      end else begin
         o_code_valid <= (count_d != 2'd0);
         o_code <= head_d.code;
         o_code_narrow <= head_d.narrow;
         o_dac_reg <= dac_d;
      end
   end
   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   a_clear_zeroes_dac: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      !clr_n_s |=> (o_dac_reg == `SDR_DAC_RESET))
      else $error("DAC register not zero during clear");
   a_load_follows_sr: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      (clr_n_s && !ld_n_s) |=> (o_dac_reg == $past(word_s2_q)))
      else $error("DAC register does not follow shift register");
   a_idle_holds_dac: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      (clr_n_s && ld_n_s) ##1 (clr_n_s && ld_n_s) |=> $stable(o_dac_reg))
      else $error("DAC register changed while latched");
   a_clear_rise_zero: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      ($rose(clr_n_s) && ld_n_s) |=> (o_dac_reg == `SDR_DAC_RESET))
      else $error("DAC register left zero after clear release");
   a_shift_advance: assert property (
      @(posedge i_link_clk) disable iff (i_reset)
      (i_load_strobe_n && i_clear_n && !narrow_sync_q[1])
         |=> (shift_q[`SDR_WIDTH_HI-1:1] == $past(shift_q[`SDR_WIDTH_HI-2:0])))
      else $error("Shift register did not advance");
   a_shift_data_in: assert property (
      @(posedge i_link_clk) disable iff (i_reset)
      (i_load_strobe_n && i_clear_n) |=> (shift_q[0] == $past(i_serial_data_in)))
      else $error("Serial bit not captured");
   a_shift_hold_load: assert property (
      @(posedge i_link_clk) disable iff (i_reset)
      !(i_load_strobe_n && i_clear_n) |=> $stable(shift_q))
      else $error("Shift register moved while disabled");
   a_narrow_width: assert property (
      @(posedge i_link_clk) disable iff (i_reset)
      narrow_sync_q[1] |=> (shift_q[`SDR_WIDTH_HI-1:`SDR_WIDTH_LO] == 2'b00))
      else $error("Narrow variant kept bits above ten");

   a_shift_narrow_adv: assert property (
      @(posedge i_link_clk) disable iff (i_reset)
      (i_load_strobe_n && i_clear_n && narrow_sync_q[1])
         |=> (shift_q[`SDR_WIDTH_LO-1:1] == $past(shift_q[`SDR_WIDTH_LO-2:0])))
      else $error("Narrow shift register did not advance");

   a_clear_over_load: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      (!clr_n_s && !ld_n_s)
         |=> (o_dac_reg == `SDR_DAC_RESET))
      else $error("Load overrode a pending clear");

   // The previous state tells a clear release apart from a plain load
   a_clear_rise_load: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      ((state_q == sdr_pkg::SDR_CLEAR) && clr_n_s && !ld_n_s)
         |=> (o_dac_reg == $past(word_s2_q)))
      else $error("Clear release with strobe low did not load held contents");

   //------------------------------------------------------------
   // Stream checks
   //------------------------------------------------------------
   a_push_on_change: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      (dac_change && !buf_full)
         |=> o_code_valid)
      else $error("New DAC code not offered on the stream");

   a_first_code_out: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      ((count_q == 2'd0) && buf_push)
         |=> (o_code_valid && (o_code == $past(dac_d))))
      else $error("Stream head differs from the new DAC code");

   a_valid_holds_stall: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      (o_code_valid && !i_code_ready)
         |=> o_code_valid)
      else $error("Code valid dropped while stalled");

   a_code_holds_stall: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      (o_code_valid && !i_code_ready)
         |=> ($stable(o_code) && $stable(o_code_narrow)))
      else $error("Stream code changed while stalled");

   a_count_bounded: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      1'b1
         |-> (count_q != 2'd3))
      else $error("Buffer count beyond its depth");

   a_full_keeps_count: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      (buf_full && !buf_pop)
         |=> (count_q == 2'd2))
      else $error("Full buffer lost or gained an entry");

   a_last_pop_empties: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      ((count_q == 2'd1) && buf_pop && !buf_push)
         |=> !o_code_valid)
      else $error("Code valid stayed high on an empty buffer");

   a_narrow_flag_out: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      ((count_q == 2'd0) && buf_push)
         |=> (o_code_narrow == $past(nar_core_q[1])))
      else $error("Variant flag of the stream code is wrong");

   // Codes of the narrow variant never carry bits above its width
   a_narrow_code_top: assert property (
      @(posedge i_core_clk) disable iff (i_reset)
      (o_code_valid && o_code_narrow)
         |-> ((o_code & ~width_mask(1'b1)) == `SDR_WIDTH_HI'(12'h000)))
      else $error("Narrow stream code has bits above ten");
endmodule // sdr_input_ctrl

/* tb/sdr_host_model.sv */
// Host-side model driving the serial link of the converter input register
`timescale 1ns/1ps
module sdr_host_model (
   // Link towards the device
   output logic o_link_clk,
   output logic o_serial_data_in
);
   initial begin
      o_link_clk = 1'b0;
      o_serial_data_in = 1'b0;
   end
   // ----------------------------------------
   // Frame sender
   // ----------------------------------------
   // MSB first
   task automatic send(input logic [15:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         o_serial_data_in = w[i];
         #24 o_link_clk = 1'b1;
         #24 o_link_clk = 1'b0;
      end
      // Released line must not look like the last bit
      o_serial_data_in = ~o_serial_data_in;
   endtask
endmodule // sdr_host_model

/* tb/sdr_input_ctrl_bench.sv */
// Self-checking bench of the serial converter input register block
`timescale 1ns/1ps
module sdr_input_ctrl_bench;
   logic clk, rst, lclk, serial_data_in, ld_n, clr_n, narrow, rdy, vld, c_nar;
   logic [11:0] code, dac, cur;
   bit stall;
   int errors = 0;
   int n_compared = 0;
   sdr_pkg::sdr_word_t q[$];
   sdr_host_model HOST (.o_link_clk(lclk), .o_serial_data_in(serial_data_in));
   sdr_input_ctrl DUT (.i_core_clk(clk), .i_reset(rst), .i_link_clk(lclk),
      .i_serial_data_in(serial_data_in), .i_load_strobe_n(ld_n), .i_clear_n(clr_n),
      .i_narrow(narrow), .i_code_ready(rdy), .o_code_valid(vld), .o_code(code),
      .o_code_narrow(c_nar), .o_dac_reg(dac));
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic chk(input string what, input logic [12:0] e, input logic [12:0] s);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Pin levels, then the DAC register after the sync delay
   task automatic step(input logic l, input logic c, input logic [11:0] e, input bit keep);
      if (keep && e !== cur) q.push_back({e, narrow});
      cur = e;
      repeat (3) @(posedge clk);
      ld_n <= l;
      clr_n <= c;
      repeat (6) @(posedge clk);
      @(negedge clk) chk("dac", {1'b0, e}, {1'b0, dac});
   endtask
   task automatic drain();
      for (int i = 0; i < 300 && q.size() > 0; i++) @(posedge clk);
      if (q.size() > 0) begin
         errors++;
         end_of_test();
      end
      repeat (4) @(posedge clk);
      @(negedge clk) chk("valid", 13'h0, {12'h0, vld});
   endtask
   always @(negedge clk) begin
      if (!rst && vld && rdy) begin
         if (q.size() > 0) begin
            chk("stream", q.pop_front(), {code, c_nar});
         end else begin
            chk("stream", 13'hx, {code, c_nar});
         end
      end
   end
   always @(posedge clk) rdy <= stall ? 1'b0 : 1'($urandom_range(1));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_of_test();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      logic [11:0] w;
      logic [9:0] v;
      rst = 1'b1;
      ld_n = 1'b1;
      clr_n = 1'b1;
      narrow = 1'b0;
      cur = 12'h0;
      void'($urandom(28));
      fork
         HOST.send(16'h0, 1);
         repeat (4) @(posedge clk);
      join
      rst <= 1'b0;
      w = 12'($urandom);
      HOST.send({4'h0, w}, 12);
      step(0, 1, w, 1);
      step(1, 1, w, 1);
      $display("test wide word done");
      w = 12'($urandom);
      HOST.send({2'b11, w, 2'b00} >> 2, 14);
      step(0, 1, w, 1);
      step(1, 1, w, 1);
      step(0, 1, w, 1);
      HOST.send({4'h0, ~w}, 12);
      step(1, 1, w, 1);
      step(0, 1, w, 1);
      step(1, 1, w, 1);
      $display("test overrun and frozen shift done");
      drain();
      stall = 1'b1;
      step(1, 0, 12'h0, 1);
      step(1, 1, 12'h0, 1);
      step(0, 1, w, 1);
      step(1, 1, w, 1);
      step(1, 0, 12'h0, 0);
      @(negedge clk) chk("full", 13'h1, {12'h0, vld});
      stall = 1'b0;
      drain();
      step(1, 1, 12'h0, 1);
      step(0, 0, 12'h0, 1);
      step(0, 1, w, 1);
      step(1, 1, w, 1);
      $display("test clear and buffer done");
      @(posedge clk) narrow <= 1'b1;
      v = 10'($urandom);
      HOST.send({6'h0, v}, 10);
      step(0, 1, {2'b00, v}, 1);
      step(1, 1, {2'b00, v}, 1);
      drain();
      $display("test narrow word done");
      end_of_test();
   end
endmodule // sdr_input_ctrl_bench
